// ===== design/bit_set_unit.sv
// bit-set modify stage: forces one selected bit of a read byte to one
`timescale 1ns/1ps
`default_nettype none
module bit_set_unit (
   dmem_port_if.unit port
);
   logic [7:0] mask;
   always_comb begin
      mask = 8'h01 << port.bitSel;
      port.modData = port.doSet ? (port.rdData | mask) : port.rdData;
   end
endmodule
`default_nettype wire

// ===== design/branch_and_bit_set_exec.sv
// execution logic: overflow/zero branches, relative branch, set file bit
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_set_exec (
   input  wire logic                               clk,
   input  wire logic                               sys_rst,
   input  wire logic [15:0]                        opcode,
   input  wire logic                               opValid,
   input  wire logic                               ovfFlag,
   input  wire logic                               zeroFlag,
   input  wire logic [3:0]                         bankSelectReg,
   input  wire logic [7:0]                         fileRdData,
   output logic [branch_bit_pkg::PC_W-1:0]         pc,
   output logic [branch_bit_pkg::ADDR_W-1:0]       fileAddr,
   output logic [7:0]                              fileWrData,
   output logic                                    fileWrEn,
   output logic                                    fileRdEn,
   output logic                                    statusWrEn,
   output logic                                    busyNop,
   output logic [1:0]                              qPhase
);
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic [branch_bit_pkg::ADDR_W-1:0] fileAddrOf(
      input logic [15:0] op, input logic [3:0] bankReg);
      logic [3:0] bank;
      bank = bankReg;
      if (!op[branch_bit_pkg::BANK_SEL_POS]) begin
         bank = (op[7:0] < branch_bit_pkg::ACCESS_SPLIT) ? branch_bit_pkg::ACCESS_BANK
                                                        : branch_bit_pkg::ACCESS_HIGH_BANK;
      end
      return {bank, op[7:0]};
   endfunction

   branch_bit_pkg::qphase_t      qState_q, qState_d;
   logic [15:0]                  op_q, op_d;
   logic                         nop_q, nop_d;
   logic [branch_bit_pkg::PC_W-1:0] pc_q, pc_d, instAddr_q, instAddr_d;
   logic [7:0]                   wr_q, wr_d;
   logic                         wrEn_q, wrEn_d;
   logic                         isBrNoOvf, isBrNonZero, isBrAlways, isSetBit, take;
   logic [branch_bit_pkg::PC_W-1:0] offs;
   dmem_port_if port ();

   always_comb begin
      isBrNoOvf   = op_q[15:8] == branch_bit_pkg::OPC_BNOVF;
      isBrNonZero = op_q[15:8] == branch_bit_pkg::OPC_BNZERO;
      isBrAlways  = op_q[15:11] == branch_bit_pkg::OPC_BRAL;
      isSetBit    = op_q[15:12] == branch_bit_pkg::OPC_BSETF;
      take        = (isBrNoOvf && !ovfFlag) || (isBrNonZero && !zeroFlag)
                    || isBrAlways;
      if (isBrAlways) begin
         offs = {{(branch_bit_pkg::PC_W-12){op_q[10]}}, op_q[10:0], 1'b0};
      end else begin
         offs = {{(branch_bit_pkg::PC_W-9){op_q[7]}}, op_q[7:0], 1'b0};
      end
   end

   // ------------------------------------------------------------
   // bit-set path through the modify unit
   // ------------------------------------------------------------
   assign port.addr   = fileAddrOf(op_q, bankSelectReg);
   assign port.bitSel = op_q[branch_bit_pkg::BIT_POS_LSB +: 3];
   assign port.doSet  = isSetBit && !nop_q;
   assign port.rdData = fileRdData;
   assign port.wrData = wr_q;
   assign port.wrEn   = wrEn_q;
   bit_set_unit u_bit (.port(port.unit));

   // ------------------------------------------------------------
   // phase sequencer and execution
   // ------------------------------------------------------------
   always_comb begin
      qState_d = qState_q;
      op_d = op_q;
      nop_d = nop_q;
      pc_d = pc_q;
      instAddr_d = instAddr_q;
      wr_d = wr_q;
      wrEn_d = 1'b0;
      unique case (qState_q)
         branch_bit_pkg::Q1_DECODE: begin
            qState_d = branch_bit_pkg::Q2_READ;
            if (!nop_q) begin
               op_d = opValid ? opcode : 16'h0000;
               instAddr_d = pc_q;
               pc_d = pc_q + branch_bit_pkg::PC_STEP;
            end
         end
         branch_bit_pkg::Q2_READ: qState_d = branch_bit_pkg::Q3_PROCESS;
         branch_bit_pkg::Q3_PROCESS: begin
            qState_d = branch_bit_pkg::Q4_WRITE;
            if (isSetBit && !nop_q) begin
               wr_d = port.modData;
               wrEn_d = 1'b1;
            end
         end
         branch_bit_pkg::Q4_WRITE: begin
            qState_d = branch_bit_pkg::Q1_DECODE;
            if (nop_q) begin
               nop_d = 1'b0;
            end else if (take) begin
               pc_d = instAddr_q + branch_bit_pkg::PC_STEP + offs;
               nop_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         qState_q <= branch_bit_pkg::Q1_DECODE;
         op_q <= 16'h0000;
         nop_q <= 1'b0;
         pc_q <= branch_bit_pkg::PC_RESET;
         instAddr_q <= branch_bit_pkg::PC_RESET;
         wr_q <= 8'h00;
         wrEn_q <= 1'b0;
      end else begin
         qState_q <= qState_d;
         op_q <= op_d;
         nop_q <= nop_d;
         pc_q <= pc_d;
         instAddr_q <= instAddr_d;
         wr_q <= wr_d;
         wrEn_q <= wrEn_d;
      end
   end

   assign pc = pc_q;
   assign fileAddr = port.addr;
   assign fileWrData = port.wrData;
   assign fileWrEn = port.wrEn;
   assign fileRdEn = (qState_q == branch_bit_pkg::Q2_READ) && isSetBit && !nop_q;
   assign statusWrEn = 1'b0;
   assign busyNop = nop_q;
   assign qPhase = qState_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_branch_if_no_overflow_cond;
      @(posedge clk) disable iff (sys_rst)
      (qState_q == branch_bit_pkg::Q4_WRITE && !nop_q && isBrNoOvf) |=> (nop_q == !$past(ovfFlag));
   endproperty
   a_branch_if_no_overflow_cond: assert property (p_branch_if_no_overflow_cond) else $error("overflow branch decision wrong");
   property p_bnz_cond;
      @(posedge clk) disable iff (sys_rst)
      (qState_q == branch_bit_pkg::Q4_WRITE && !nop_q && isBrNonZero)
      |=> (nop_q == !$past(zeroFlag));
   endproperty
   a_bnz_cond: assert property (p_bnz_cond) else $error("zero branch decision wrong");
   property p_target;
      @(posedge clk) disable iff (sys_rst)
      (qState_q == branch_bit_pkg::Q4_WRITE && !nop_q && take)
      |=> (pc_q == $past(instAddr_q) + branch_bit_pkg::PC_STEP + $past(offs));
   endproperty
   a_target: assert property (p_target) else $error("branch target wrong");
   property p_cond_offs;
      @(posedge clk) disable iff (sys_rst)
      (isBrNonZero || isBrNoOvf) |-> (offs[8:0] == {op_q[7:0], 1'b0}) && (offs[20] == op_q[7]);
   endproperty
   a_cond_offs: assert property (p_cond_offs) else $error("short offset wrong");
   property p_bra_offs;
      @(posedge clk) disable iff (sys_rst)
      isBrAlways |-> (offs[11:0] == {op_q[10:0], 1'b0}) && (offs[20] == op_q[10]);
   endproperty
   a_bra_offs: assert property (p_bra_offs) else $error("long offset wrong");
   property p_nop_cycle;
      @(posedge clk) disable iff (sys_rst)
      $rose(nop_q) |-> nop_q [*4] ##1 !nop_q;
   endproperty
   a_nop_cycle: assert property (p_nop_cycle) else $error("idle cycle length wrong");
   property p_bra_two;
      @(posedge clk) disable iff (sys_rst)
      (qState_q == branch_bit_pkg::Q4_WRITE && !nop_q && isBrAlways) |=> nop_q;
   endproperty
   a_bra_two: assert property (p_bra_two) else $error("always branch not two cycles");
   property p_not_taken;
      @(posedge clk) disable iff (sys_rst)
      (qState_q == branch_bit_pkg::Q4_WRITE && !nop_q && !take)
      |=> (pc_q == $past(pc_q)) && !nop_q;
   endproperty
   a_not_taken: assert property (p_not_taken) else $error("untaken branch wrote PC");
   property p_no_status;
      @(posedge clk) disable iff (sys_rst) !statusWrEn;
   endproperty
   a_no_status: assert property (p_no_status) else $error("status written");
   property p_bsf_write;
      @(posedge clk) disable iff (sys_rst)
      fileWrEn |-> qState_q == branch_bit_pkg::Q4_WRITE && isSetBit
         && fileWrData[op_q[11:9]] && ($past(fileRdData) | fileWrData) == fileWrData;
   endproperty
   a_bsf_write: assert property (p_bsf_write) else $error("bit set write wrong");
   property p_bank;
      @(posedge clk) disable iff (sys_rst)
      (isSetBit && op_q[8]) |-> fileAddr[11:8] == bankSelectReg;
   endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");
   // the modify unit sets the chosen bit and passes every other bit through
   property p_only_bit;
      @(posedge clk) disable iff (sys_rst)
      port.doSet |-> port.modData[port.bitSel]
         && (((port.modData ^ port.rdData) & ~(8'h01 << port.bitSel)) == 8'h00);
   endproperty
   a_only_bit: assert property (p_only_bit) else $error("bit set touched other bits");
   c_no_ovf: cover property (@(posedge clk) $rose(nop_q) && $past(isBrNoOvf));
   c_non_zero: cover property (@(posedge clk) $rose(nop_q) && $past(isBrNonZero));
   c_always: cover property (@(posedge clk) $rose(nop_q) && $past(isBrAlways));
   c_set_bit: cover property (@(posedge clk) fileWrEn);
endmodule
`default_nettype wire

// ===== design/branch_bit_pkg.sv
// package: constants and types for the branch and bit-set execution block
package branch_bit_pkg;
   localparam int PC_W = 21;
   localparam int ADDR_W = 12;
   localparam logic [7:0] OPC_BNOVF = 8'hE5;
   localparam logic [7:0] OPC_BNZERO = 8'hE1;
   localparam logic [4:0] OPC_BRAL = 5'h1A;
   localparam logic [3:0] OPC_BSETF = 4'h8;
   localparam logic [3:0] ACCESS_BANK = 4'h0;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam int BIT_POS_LSB = 9;
   localparam int BANK_SEL_POS = 8;
   typedef enum logic [1:0] {Q1_DECODE, Q2_READ, Q3_PROCESS, Q4_WRITE} qphase_t;
endpackage

// ===== design/dmem_port_if.sv
// interface: data-memory access lines between the core and its bit-modify unit
`timescale 1ns/1ps
`default_nettype none
interface dmem_port_if;
   logic [11:0] addr;
   logic [7:0]  rdData;
   logic [7:0]  wrData;
   logic        wrEn;
   logic [2:0]  bitSel;
   logic        doSet;
   logic [7:0]  modData;
   modport core (output addr, output bitSel, output doSet, input modData);
   modport unit (input bitSel, input doSet, input rdData, output modData);
endinterface
`default_nettype wire

// ===== tb/branch_and_bit_set_exec_bench.sv
// self-checking bench for the branch and bit-set execution block
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_set_exec_bench;
   typedef struct {logic [15:0] op; logic ovf; logic zro; logic [3:0] bank; logic [7:0] rd;} row_t;
   logic                              clk, sysRst, opValid, ovfFlag, zeroFlag;
   logic [15:0]                       opcode;
   logic [3:0]                        bankSelectReg;
   logic [7:0]                        fileRdData, fileWrData;
   logic [branch_bit_pkg::PC_W-1:0]   pc;
   logic [branch_bit_pkg::ADDR_W-1:0] fileAddr;
   logic                              fileWrEn, fileRdEn, statusWrEn, busyNop;
   logic [1:0]                        qPhase;
   int                                error_cnt = 0;
   int                                compares = 0;
   row_t rows[11] = '{'{16'hD3FF, 1'b0, 1'b0, 4'h0, 8'h00}, '{16'hE57F, 1'b0, 1'b1, 4'h0, 8'h00},
      '{16'hE580, 1'b1, 1'b0, 4'h0, 8'h00}, '{16'hE180, 1'b1, 1'b0, 4'h0, 8'h00},
      '{16'hE105, 1'b0, 1'b1, 4'h0, 8'h00}, '{16'hD400, 1'b1, 1'b1, 4'h0, 8'h00},
      '{16'h8E45, 1'b0, 1'b0, 4'h3, 8'h0A}, '{16'h8090, 1'b1, 1'b1, 4'h3, 8'hFE},
      '{16'h8B20, 1'b0, 1'b0, 4'h5, 8'h0A}, '{16'h8280, 1'b0, 1'b0, 4'h7, 8'h02},
      '{16'hE700, 1'b0, 1'b0, 4'h0, 8'h00}};
   branch_and_bit_set_exec i_dut (.clk(clk), .sys_rst(sysRst), .opcode(opcode),
      .opValid(opValid), .ovfFlag(ovfFlag), .zeroFlag(zeroFlag), .bankSelectReg(bankSelectReg),
      .fileRdData(fileRdData), .pc(pc), .fileAddr(fileAddr), .fileWrData(fileWrData),
      .fileWrEn(fileWrEn), .fileRdEn(fileRdEn), .statusWrEn(statusWrEn), .busyNop(busyNop),
      .qPhase(qPhase));
   // ------------------------------------------------------------
   // compare and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // one instruction: launch at Q1, watch eight cycles
   // ------------------------------------------------------------
   task automatic run_op(input row_t r);
      logic [20:0] base, off, expPc;
      logic [11:0] expAddr, wrAddr, rdAddr;
      logic [7:0]  wrData;
      logic        brAlways, tk, setBit;
      int          wr = 0, rdc = 0, nop = 0, st = 0, k = 0;
      while (!(qPhase === branch_bit_pkg::Q_FIRST && busyNop === 1'b0) && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk(k < 20, 1, "phase alignment");
      base = pc;
      brAlways = (r.op[15:11] == branch_bit_pkg::OPC_BRAL);
      setBit = (r.op[15:12] == branch_bit_pkg::OPC_BSETF);
      tk = brAlways || (r.op[15:8] == 8'hE5 && !r.ovf) || (r.op[15:8] == 8'hE1 && !r.zro);
      off = brAlways ? {{9{r.op[10]}}, r.op[10:0], 1'b0} : {{12{r.op[7]}}, r.op[7:0], 1'b0};
      expPc = tk ? base + 21'h000002 + off : base + 21'h000004;
      expAddr = r.op[8] ? {r.bank, r.op[7:0]} : (r.op[7:0] < branch_bit_pkg::ACCESS_SPLIT ?
         {4'h0, r.op[7:0]} : {4'hF, r.op[7:0]});
      opcode = r.op;
      opValid = 1'b1;
      ovfFlag = r.ovf;
      zeroFlag = r.zro;
      bankSelectReg = r.bank;
      fileRdData = r.rd;
      for (int i = 1; i <= 8; i++) begin
         @(negedge clk);
         if (i == 1) chk(pc, base + 21'h000002, "pc step");
         // taken branches keep the opcode valid to show it is refused while idle
         if (i == 1 && !tk) opValid = 1'b0;
         if (fileWrEn === 1'b1) begin
            wr++;
            wrData = fileWrData;
            wrAddr = fileAddr;
         end
         if (fileRdEn === 1'b1) begin
            rdc++;
            rdAddr = fileAddr;
         end
         if (busyNop === 1'b1) nop++;
         if (statusWrEn !== 1'b0) st++;
      end
      chk(pc, expPc, "pc after op");
      chk(nop, tk ? 4 : 0, "idle cycles");
      chk(st, 0, "status write");
      chk(wr, setBit ? 1 : 0, "write count");
      chk(rdc, setBit ? 1 : 0, "read count");
      if (setBit) begin
         chk(wrData, r.rd | (8'h01 << r.op[11:9]), "written byte");
         chk(wrAddr, expAddr, "write address");
         chk(rdAddr, expAddr, "read address");
      end
   endtask
   // ------------------------------------------------------------
   // clock, watchdog, sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      sysRst = 1'b1;
      opValid = 1'b0;
      opcode = 16'h0000;
      ovfFlag = 1'b0;
      zeroFlag = 1'b0;
      bankSelectReg = 4'h0;
      fileRdData = 8'h00;
      repeat (8) @(negedge clk);
      sysRst = 1'b0;
      foreach (rows[i]) run_op(rows[i]);
      // reset in the middle of a taken branch
      opcode = 16'hD005;
      opValid = 1'b1;
      repeat (5) @(negedge clk);
      sysRst = 1'b1;
      repeat (2) @(negedge clk);
      chk(pc, 0, "pc in reset");
      chk(busyNop, 0, "idle in reset");
      chk(qPhase, 0, "phase in reset");
      chk(fileWrEn, 0, "write in reset");
      sysRst = 1'b0;
      run_op(rows[8]);
      tally_and_finish();
   end
endmodule
`default_nettype wire
